// ---- hw/acl_top.v ----
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "acl_regs.vh"
module acl_top
(
   // clock and reset
   input  wire        ref_clk,
   input  wire        sys_rst,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // converter core
   input  wire        convDone,
   input  wire [11:0] convData,
   output reg         sampleEn,
   output reg  [1:0]  posInSel,
   output reg  [1:0]  negInSel,
   output reg         negGround,
   output reg  [2:0]  fullScaleSel,
   output reg  [2:0]  rateSel,
   // alert-response link
   input  wire [6:0]  devAddr,
   input  wire        araStart,
   input  wire        sclIn,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe,
   // open-drain alert pin
   output reg         alertOut,
   output reg         alertOe
);

   // =====================================================
   // declarations
   reg  [15:0] config_q;
   reg  [15:0] lower_q;
   reg  [15:0] upper_q;
   reg  [15:0] result_q;
   reg         alert_q;
   reg         statusBit_q;
   reg  [2:0]  qcnt_q;
   reg         cfgChg_q;
   reg         sclDly_q;
   reg         araBusy_q;
   reg         araLost_q;
   reg         araWon_q;
   reg  [3:0]  araBit_q;
   reg  [7:0]  araShift_q;
   wire        sclS;
   wire        sdaS;
   wire        tick;
   wire        wbReq;
   wire        wbWr;
   wire        wbRd;
   wire [15:0] newRes;
   wire        above;
   wire        below;
   wire        winMode;
   wire        latchEn;
   wire [1:0]  queue;
   wire        compOn;
   wire        qual;
   wire [2:0]  qneed;
   wire        qhit;
   wire        setAlert;
   wire        relAlert;
   wire        resRead;
   wire        araClear;
   wire        sclRise;
   wire        sclFall;

   // merge a write into a 16-bit register by byte lanes
   function [15:0] laneMerge;
      input [15:0] old;
      input [15:0] din;
      input [1:0]  sel;
      begin
         laneMerge[7:0]  = sel[0] ? din[7:0]  : old[7:0];
         laneMerge[15:8] = sel[1] ? din[15:8] : old[15:8];
      end
   endfunction

   // =====================================================
   // link inputs and sample clock
   acl_sync2 u_sclSync
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .asyncIn (sclIn),
      .syncOut (sclS)
   );

   acl_sync2 u_sdaSync
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .asyncIn (sdaIn),
      .syncOut (sdaS)
   );

   acl_tick_div #(.DIV(`ACL_SAMPLE_DIV)) u_tick
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   // =====================================================
   // wishbone decode
   assign wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wbWr    = wbReq & wb_we_i;
   assign wbRd    = wbReq & ~wb_we_i;
   assign resRead = wbRd & (wb_adr_i == `ACL_OFS_RESULT);

   // ack one cycle after the request, read data with it
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wbReq;
         wb_dat_o <= 32'h00000000;
         if (wbRd)
         begin
            case (wb_adr_i)
               `ACL_OFS_RESULT: wb_dat_o <= {16'h0000, result_q};
               `ACL_OFS_CONFIG: wb_dat_o <= {16'h0000, config_q};
               `ACL_OFS_LOWER:  wb_dat_o <= {16'h0000, lower_q};
               `ACL_OFS_UPPER:  wb_dat_o <= {16'h0000, upper_q};
               `ACL_OFS_STATUS: wb_dat_o <= {28'h0000000, araWon_q, araBusy_q,
                                             statusBit_q, alert_q};
               default:         wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // writable registers; a change of settings is flagged for the queue
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         config_q <= `ACL_RST_CONFIG;
         lower_q  <= `ACL_RST_LOWER;
         upper_q  <= `ACL_RST_UPPER;
         cfgChg_q <= 1'b0;
      end
      else
      begin
         cfgChg_q <= 1'b0;
         if (wbWr && wb_adr_i == `ACL_OFS_CONFIG)
         begin
            config_q <= laneMerge(config_q, wb_dat_i[15:0], wb_sel_i[1:0]);
            cfgChg_q <= 1'b1;
         end
         if (wbWr && wb_adr_i == `ACL_OFS_LOWER)
         begin
            lower_q  <= laneMerge(lower_q, wb_dat_i[15:0], wb_sel_i[1:0]) & 16'hFFF0;
            cfgChg_q <= 1'b1;
         end
         if (wbWr && wb_adr_i == `ACL_OFS_UPPER)
         begin
            upper_q  <= laneMerge(upper_q, wb_dat_i[15:0], wb_sel_i[1:0]) & 16'hFFF0;
            cfgChg_q <= 1'b1;
         end
      end
   end

   // =====================================================
   // analog control decode
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         posInSel     <= 2'h0;
         negInSel     <= 2'h1;
         negGround    <= 1'b0;
         fullScaleSel <= 3'h2;
         rateSel      <= 3'h4;
         sampleEn     <= 1'b0;
      end
      else
      begin
         sampleEn  <= tick;
         negGround <= 1'b0;
         case (config_q[`ACL_CFG_INSEL])
            3'h0, 3'h1:
            begin
               posInSel  <= 2'h0;
               negInSel  <= 2'h1;
            end
            3'h2:
            begin
               posInSel  <= 2'h1;
               negInSel  <= 2'h3;
            end
            3'h3:
            begin
               posInSel  <= 2'h2;
               negInSel  <= 2'h3;
            end
            default:
            begin
               posInSel  <= config_q[1:0];
               negInSel  <= 2'h0;
               negGround <= 1'b1;
            end
         endcase
         if (config_q[`ACL_CFG_GAIN] > `ACL_GAIN_MAX)
            fullScaleSel <= `ACL_GAIN_MAX;
         else
            fullScaleSel <= config_q[`ACL_CFG_GAIN];
         if (config_q[`ACL_CFG_RATE] > `ACL_RATE_MAX)
            rateSel <= `ACL_RATE_MAX;
         else
            rateSel <= config_q[`ACL_CFG_RATE];
      end
   end

   // =====================================================
   // comparator
   assign winMode = config_q[`ACL_CFG_WINDOW];
   assign latchEn = config_q[`ACL_CFG_LATCH];
   assign queue   = config_q[`ACL_CFG_QUEUE];
   assign compOn  = (queue != `ACL_QUEUE_OFF);
   assign newRes  = {convData, 4'h0};
   assign above   = $signed(newRes) > $signed(upper_q);
   assign below   = $signed(newRes) < $signed(lower_q);
   assign qual    = winMode ? (above | below) : above;
   // consecutive count 1, 2 or 4
   assign qneed   = (queue == 2'h0) ? 3'h1 : ((queue == 2'h1) ? 3'h2 : 3'h4);
   assign qhit    = (qcnt_q + 3'h1) >= qneed;
   assign setAlert = compOn & convDone & qual & qhit;
   assign relAlert = convDone & ~latchEn & (winMode ? ~(above | below) : below);
   assign araClear = araBusy_q & sclRise & (araBit_q == `ACL_ARA_BITS - 4'h1)
                     & ~araLost_q & ~(~araShift_q[7] & sdaS) & ~(araShift_q[7] & ~sdaS);

   always @(posedge ref_clk)
   begin
      if (sys_rst)
         qcnt_q <= 3'h0;
      else if (cfgChg_q || !compOn)
         qcnt_q <= 3'h0;
      else if (convDone && !qual)
         qcnt_q <= 3'h0;
      else if (convDone && !qhit)
         qcnt_q <= qcnt_q + 3'h1;
   end

   // result register and alert state; a new set beats any clear
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         result_q    <= 16'h0000;
         alert_q     <= 1'b0;
         statusBit_q <= 1'b0;
      end
      else
      begin
         if (convDone)
            result_q <= newRes;
         if (!compOn)
            alert_q <= 1'b0;
         else if (setAlert)
         begin
            alert_q <= 1'b1;
            statusBit_q <= above | ~winMode;
         end
         // latched alert clears only on read, response or comparator disable
         else if (latchEn && (resRead || araClear))
            alert_q <= 1'b0;
         else if (relAlert)
            alert_q <= 1'b0;
      end
   end

   // =====================================================
   // alert-response arbitration
   assign sclRise = sclS & ~sclDly_q;
   assign sclFall = ~sclS & sclDly_q;

   // shift address and status out, lose on a low bus when released
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sclDly_q   <= 1'b1;
         araBusy_q  <= 1'b0;
         araLost_q  <= 1'b0;
         araWon_q   <= 1'b0;
         araBit_q   <= 4'h0;
         araShift_q <= 8'hFF;
      end
      else
      begin
         sclDly_q <= sclS;
         if (araStart && alert_q && !araBusy_q)
         begin
            araBusy_q  <= 1'b1;
            araLost_q  <= 1'b0;
            araWon_q   <= 1'b0;
            araBit_q   <= 4'h0;
            araShift_q <= {devAddr, statusBit_q};
         end
         else if (araBusy_q && sclRise)
         begin
            if (araShift_q[7] && !sdaS)
               araLost_q <= 1'b1;
            if (araBit_q == `ACL_ARA_BITS - 4'h1)
               araWon_q <= araClear;
            araBit_q <= araBit_q + 4'h1;
         end
         // last bit held until scl falls, so sda never moves while scl is high
         else if (araBusy_q && sclFall && araBit_q != 4'h0)
         begin
            araShift_q <= {araShift_q[6:0], 1'b1};
            araBusy_q  <= (araBit_q != `ACL_ARA_BITS);
         end
      end
   end

   // =====================================================
   // open-drain pins: sda low bits in arbitration, alert pin
   // polarity, release while disabled
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sdaOut   <= 1'b0;
         sdaOe    <= 1'b0;
         alertOut <= 1'b0;
         alertOe  <= 1'b0;
      end
      else
      begin
         sdaOut   <= 1'b0;
         sdaOe    <= araBusy_q & ~araLost_q & ~araShift_q[7];
         alertOut <= 1'b0;
         alertOe  <= compOn & (config_q[`ACL_CFG_POL] ? ~alert_q : alert_q);
      end
   end

endmodule

// ---- hw/acl_regs.vh ----
// Contract
// - Input select codes 0-3 pick differential pairs 0/1, 0/1, 1/3, 2/3.
// - Input select codes 4-7 measure inputs 0-3 single-ended, negative input grounded.
// - Input is sampled at 250 kHz derived from the internal clock.
// - Gain select sets full scale; codes 5 to 7 all give 0.256 V.
// - Rate select codes 0-6 give 128 to 3300 samples per second.
// - Each conversion yields a 12-bit result examined by the comparator.
// - Traditional mode asserts the alert when a result exceeds the upper limit.
// - Traditional mode releases the alert only when a result falls below lower limit.
// - Window mode asserts the alert when a result is outside either limit.
// - With latch enabled the alert stays asserted after results return inside.
// - Latched alert clears on a won alert-response read or result read.
// - Alert-response arbitration: lowest address wins; only the winner clears.
// - Traditional mode response status bit is one for an upper-limit alert.
// - Window mode status bit is one for upper, zero for lower cause.
// - Alert asserts only after 1, 2 or 4 consecutive qualifying conversions.
// - One queue setting disables the comparator and releases the alert pin.
// - Polarity setting selects active-high or active-low alert level.
// - Alert pin is open-drain: only pulled low or released.
// - Queue code 11 disables; other codes keep the comparator active.
// - Results held as 12-bit two's complement, left-aligned, low four bits zero.
`ifndef ACL_REGS_VH
`define ACL_REGS_VH

// =====================================================
// register byte offsets
`define ACL_OFS_RESULT  8'h00
`define ACL_OFS_CONFIG  8'h04
`define ACL_OFS_LOWER   8'h08
`define ACL_OFS_UPPER   8'h0C
`define ACL_OFS_STATUS  8'h10

// =====================================================
// config fields
`define ACL_CFG_INSEL   2:0
`define ACL_CFG_GAIN    5:3
`define ACL_CFG_RATE    8:6
`define ACL_CFG_WINDOW  9
`define ACL_CFG_POL     10
`define ACL_CFG_LATCH   11
`define ACL_CFG_QUEUE   13:12
`define ACL_QUEUE_OFF   2'h3
`define ACL_GAIN_MAX    3'h5
`define ACL_RATE_MAX    3'h6

// =====================================================
// reset values
`define ACL_RST_CONFIG  16'h3110
`define ACL_RST_LOWER   16'h8000
`define ACL_RST_UPPER   16'h7FF0

// =====================================================
// timing
`define ACL_CLK_HZ      200000000
`define ACL_SAMPLE_HZ   250000
`define ACL_SAMPLE_DIV  (`ACL_CLK_HZ / `ACL_SAMPLE_HZ)
`define ACL_ARA_BITS    4'h8

`endif

// ---- hw/acl_sync2.v ----
`timescale 1ns/1ps
module acl_sync2
(
   // clock and reset
   input  wire ref_clk,
   input  wire sys_rst,
   // asynchronous level in, synchronous level out
   input  wire asyncIn,
   output wire syncOut
);

   reg meta_q;
   reg sync_q;

   // =====================================================
   // two flip-flop synchroniser, idles high like a bus line
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end
      else
      begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;

endmodule

// ---- hw/acl_tick_div.v ----
`timescale 1ns/1ps
`include "acl_regs.vh"
module acl_tick_div
#(
   parameter DIV = `ACL_SAMPLE_DIV
)
(
   // clock and reset
   input  wire ref_clk,
   input  wire sys_rst,
   // one-cycle enable at the divided rate
   output reg  tick
);

   reg [15:0] cnt_q;

   // =====================================================
   // free running divider
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end
      else if (cnt_q == DIV[15:0] - 16'h0001)
      begin
         cnt_q <= 16'h0000;
         tick  <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 16'h0001;
         tick  <= 1'b0;
      end
   end

endmodule

// ---- tb/acl_monitor.sv ----
`timescale 1ns/1ps
module acl_monitor
(
   // clock and reset
   input wire        ref_clk,
   input wire        sys_rst,
   // wishbone
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // converter core
   input wire        sampleEn,
   input wire [1:0]  posInSel,
   input wire [1:0]  negInSel,
   input wire        negGround,
   input wire [2:0]  fullScaleSel,
   input wire [2:0]  rateSel,
   // pins
   input wire        sdaOut,
   input wire        alertOut
);
   // ===============================
   // sample spacing counter
   logic [9:0] gapCnt_q;
   logic       gapSeen_q;
   wire        rdReq = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   // cycles since the last sample pulse
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || sampleEn)
         gapCnt_q <= 10'h000;
      else
         gapCnt_q <= gapCnt_q + 10'h001;
      if (sys_rst)
         gapSeen_q <= 1'b0;
      else if (sampleEn)
         gapSeen_q <= 1'b1;
   end

   // ===============================
   // assertions
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   unmapped_zero_a: assert property (rdReq && wb_adr_i > 8'h10 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   result_align_a: assert property (
      rdReq && wb_adr_i == 8'h00 |=> wb_dat_o[3:0] == 4'h0 && wb_dat_o[31:16] == 16'h0)
      else $error("result word not left aligned");
   sample_gap_a: assert property (
      gapSeen_q |-> sampleEn == (gapCnt_q == 10'd799))
      else $error("sample pulse spacing wrong");
   mux_pair_a: assert property (!negGround |->
      (posInSel == 2'h0 && negInSel == 2'h1) || (posInSel != 2'h3 && negInSel == 2'h3
      && posInSel != 2'h0))
      else $error("illegal differential pair");
   single_end_a: assert property (negGround |-> negInSel == 2'h0)
      else $error("grounded negative input still routed");
   gain_clamp_a: assert property (fullScaleSel <= 3'h5)
      else $error("gain code above clamp");
   rate_clamp_a: assert property (rateSel <= 3'h6)
      else $error("rate code above clamp");
   drain_only_a: assert property (!alertOut && !sdaOut)
      else $error("open-drain pin driven high");

   // main scenarios reached
   cover property (sampleEn && gapSeen_q);
   cover property (negGround);
   cover property (rdReq && wb_adr_i == 8'h00);
endmodule

bind acl_top acl_monitor u_acl_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sampleEn(sampleEn), .posInSel(posInSel),
   .negInSel(negInSel), .negGround(negGround), .fullScaleSel(fullScaleSel),
   .rateSel(rateSel), .sdaOut(sdaOut), .alertOut(alertOut));

// ---- tb/acl_host.sv ----
`timescale 1ns/1ps
module acl_host
(
   // clock
   input  wire ref_clk,
   // link to the device
   input  wire sdaOe,
   output reg  araStart,
   output reg  sclIn,
   output wire sdaIn
);
   // ===============================
   // wired-and data line with pull-up
   reg rivalPull = 1'b0;
   assign sdaIn = !(sdaOe || rivalPull);

   // idle bus: clock high, no request
   initial
   begin
      araStart = 1'b0;
      sclIn = 1'b1;
   end

   // one alert-response byte; rival 8'hFF means no other device
   task ara(input [7:0] rival, output [7:0] seen);
      integer i;
      begin
         sclIn <= 1'b0;
         @(posedge ref_clk);
         araStart <= 1'b1;
         @(posedge ref_clk);
         araStart <= 1'b0;
         // scl half period of 8 clocks, 80 ns per bit
         for (i = 7; i >= 0; i = i - 1)
         begin
            rivalPull <= !rival[i];
            repeat (8) @(posedge ref_clk);
            sclIn <= 1'b1;
            seen[i] = sdaIn;
            repeat (8) @(posedge ref_clk);
            sclIn <= 1'b0;
         end
         rivalPull <= 1'b0;
         repeat (8) @(posedge ref_clk);
         sclIn <= 1'b1;
      end
   endtask
endmodule

// ---- tb/acl_top_test.sv ----
`timescale 1ns/1ps
module acl_top_test;
   // ===============================
   // stimulus and observed signals
   reg         ref_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         cyc = 1'b0;
   reg         stb = 1'b0;
   reg         we = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg  [31:0] datI = 32'h0;
   reg         convDone = 1'b0;
   reg  [11:0] convData = 12'h000;
   wire [31:0] datO;
   wire        ack, sampleEn, negGround, sdaOut, sdaOe, alertOut, alertOe;
   wire        araStart, sclIn, sdaIn;
   wire [1:0]  posInSel, negInSel;
   wire [2:0]  fullScaleSel, rateSel;
   wire        alertPin = ~alertOe;   // pulled up when released
   integer     nFail = 0;
   integer     comparisons = 0;
   integer     i;
   reg  [15:0] rdv;
   reg  [7:0]  seen;

   always #2.5 ref_clk = ~ref_clk;

   acl_top u_acl_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(datI), .wb_dat_o(datO),
      .wb_ack_o(ack), .convDone(convDone), .convData(convData), .sampleEn(sampleEn),
      .posInSel(posInSel), .negInSel(negInSel), .negGround(negGround),
      .fullScaleSel(fullScaleSel), .rateSel(rateSel), .devAddr(7'h49),
      .araStart(araStart), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .alertOut(alertOut), .alertOe(alertOe));

   acl_host u_acl_host (.ref_clk(ref_clk), .sdaOe(sdaOe), .araStart(araStart),
      .sclIn(sclIn), .sdaIn(sdaIn));

   // ===============================
   // compare, bus and converter tasks
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp)
         begin
            nFail = nFail + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   task wbx(input w, input [7:0] a, input [15:0] d);
      begin
         @(posedge ref_clk);
         chk(ack, 1'b0); // ack dropped after the last answer
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         datI <= {16'h0, d};
         // wait as long as the answer takes; the watchdog bounds it
         do
            @(posedge ref_clk);
         while (ack !== 1'b1);
         rdv = datO[15:0];
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask

   task rdc(input [7:0] a, input [15:0] e);
      begin
         wbx(1'b0, a, 16'h0);
         chk(rdv, e);
      end
   endtask

   task pin(input p);
      begin
         repeat (2) @(posedge ref_clk);
         chk(alertPin, p);
      end
   endtask

   task cv(input [11:0] d, input p);
      begin
         @(posedge ref_clk);
         convDone <= 1'b1;
         convData <= d;
         @(posedge ref_clk);
         convDone <= 1'b0;
         pin(p);
      end
   endtask

   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, nFail);
         if (nFail == 0 && comparisons > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   // watchdog far beyond the expected run
   initial
   begin
      #100000;
      nFail = nFail + 1;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out;
   end

   // ===============================
   // test sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wbx(1'b1, 8'h14, 16'hFFFF);
      wbx(1'b1, 8'h00, 16'hFFFF);
      rdc(8'h00, 16'h0000);
      rdc(8'h04, 16'h3110);
      rdc(8'h08, 16'h8000);
      rdc(8'h0C, 16'h7FF0);
      rdc(8'h14, 16'h0000);
      pin(1'b1);
      $display("test reset values done");
      for (i = 0; i < 8; i = i + 1)
      begin
         wbx(1'b1, 8'h04, 16'h3000 | (i << 6) | (i << 3) | i);
         repeat (2) @(posedge ref_clk);
         chk(negGround, i >= 4);
         chk(posInSel, i < 4 ? (i == 3 ? 2 : i == 2) : i - 4);
         chk(negInSel, i < 4 ? (i < 2 ? 1 : 3) : 0);
         chk(fullScaleSel, i > 5 ? 5 : i);
         chk(rateSel, i > 6 ? 6 : i);
      end
      $display("test decoding done");
      wbx(1'b1, 8'h0C, 16'h1000);
      wbx(1'b1, 8'h08, 16'hF000);
      wbx(1'b1, 8'h04, 16'h0000);
      cv(12'h200, 1'b0);
      rdc(8'h00, 16'h2000);
      cv(12'h000, 1'b0);
      cv(12'hE00, 1'b1);
      wbx(1'b1, 8'h04, 16'h1000);
      cv(12'h200, 1'b1);
      cv(12'h200, 1'b0);
      $display("test traditional done");
      wbx(1'b1, 8'h04, 16'h0200);
      cv(12'h000, 1'b1);
      cv(12'hE00, 1'b0);
      cv(12'h000, 1'b1);
      cv(12'h200, 1'b0);
      $display("test window done");
      wbx(1'b1, 8'h04, 16'h2000);
      cv(12'hE00, 1'b1);
      repeat (3) cv(12'h200, 1'b1);
      cv(12'h000, 1'b1);
      repeat (3) cv(12'h200, 1'b1);
      wbx(1'b1, 8'h04, 16'h2000);
      repeat (3) cv(12'h200, 1'b1);
      cv(12'h200, 1'b0);
      wbx(1'b1, 8'h04, 16'h0400);
      cv(12'hE00, 1'b0);
      cv(12'h200, 1'b1);
      $display("test queue and polarity done");
      wbx(1'b1, 8'h04, 16'h0200);
      cv(12'h000, 1'b1);
      wbx(1'b1, 8'h04, 16'h0A00);
      cv(12'h200, 1'b0);
      cv(12'h000, 1'b0);
      rdc(8'h00, 16'h0000);
      pin(1'b1);
      wbx(1'b1, 8'h04, 16'h0800);
      cv(12'h200, 1'b0);
      u_acl_host.ara(8'hFF, seen);
      chk(seen, 8'h93);
      pin(1'b1);
      wbx(1'b1, 8'h04, 16'h0A00);
      cv(12'hE00, 1'b0);
      u_acl_host.ara(8'hFF, seen);
      chk(seen, 8'h92);
      pin(1'b1);
      cv(12'h200, 1'b0);
      u_acl_host.ara(8'h91, seen);
      chk(seen, 8'h91);
      pin(1'b0);
      rdc(8'h00, 16'h2000);
      pin(1'b1);
      $display("test latch and response done");
      wbx(1'b1, 8'h04, 16'h3000);
      cv(12'h200, 1'b1);
      cv(12'hE00, 1'b1);
      $display("test disable done");
      close_out;
   end
endmodule
